// ==== rtl/rate_trim_divider.sv ====
`timescale 1ns/1ps
module rate_trim_divider #(
	parameter int DIV_W = rtc_irq_pkg::CNT_W
) (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic reset_i,
	input  wire logic ce_i,
	// timebase link
	tick_if.div       link
);
	import rtc_irq_pkg::*;

	if (DIV_W < CNT_W) begin : g_chk
		$error("divider too narrow for a trimmed second");
	end

	typedef struct packed {
		logic [DIV_W-1:0] cnt;
		logic [SEC_W-1:0] ivl;
		logic             sec_tick;
	} div_state_t;

	div_state_t s_q;
	div_state_t s_d;

	// signed step count from the bit-reversed field, then trimmed terminal count
	always_comb begin
		logic signed [7:0] steps;
		int                term;
		int                ivl_len;
		steps       = '0;
		term        = 0;
		ivl_len     = 0;
		s_d         = s_q;
		s_d.sec_tick = 1'b0;
		for (int i = 0; i < 7; i++) begin
			steps[i] = link.trim[7-i];
		end
		steps[7] = steps[6];
		ivl_len = link.trim[TRIM_IVL_BIT] ? LONG_IVL_S : SHORT_IVL_S;
		// one second per interval is shortened or stretched; crystal untouched
		term = (s_q.ivl == '0) ? XTAL_HZ - TRIM_UNIT * int'(steps) : XTAL_HZ;
		if (link.restart) begin
			s_d.cnt = '0;
		end else if (link.xtal_tick) begin
			if (int'(s_q.cnt) >= term - 1) begin
				s_d.cnt      = '0;
				s_d.sec_tick = 1'b1;
				s_d.ivl      = (int'(s_q.ivl) >= ivl_len - 1) ? '0 : SEC_W'(s_q.ivl + 1'b1);
			end else begin
				s_d.cnt = DIV_W'(s_q.cnt + 1'b1);
			end
		end
	end

	// state register, frozen while the clock enable is low
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			s_q <= '0;
		end else if (ce_i) begin
			s_q <= s_d;
		end
	end

	assign link.sec_tick = s_q.sec_tick;
	assign link.div_cnt  = s_q.cnt[CNT_W-1:0];
endmodule : rate_trim_divider

// ==== rtl/rtc_irq_output_and_trim.sv ====
// Operation
// - user-set frequency pin level is the AND of the selected divider taps
// - frequency output runs while its enable is set, stops when cleared
// - edge mode pulls pin low at first minute carry until enable cleared
// - minute event lasts 7.81 ms; disable releases, re-enable inside drives low
// - periodic mode 1 gives one-minute 50% square from first carry
// - periodic 1 disabled in low phase releases; re-enable then drives low
// - periodic mode 2, pin a only, 7.81 ms low pulse at each carry
// - reading time may postpone the minute carry by at most 0.5 s
// - writing time shifts the next mode 2 pulse by write moment and value
// - power-up sets power-on flag bit 0 and 1 Hz on pin a
// - trim adds or removes divider counts; crystal never altered
// - trim bit 0 picks 20 s or 60 s correction interval
// - steps 3.052 or 1.017 ppm over the documented spans
// - 7-bit trim value bit-reversed in bits 7..1, lsb at bit 7
// - power-on loads status 2 so pin a gives 1 Hz frequency output
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
module rtc_irq_output_and_trim #(
	parameter int FREQ_TAPS_P = rtc_irq_pkg::FREQ_TAPS
) (
	// clock, reset, enable
	input  wire logic                              clk_i,
	input  wire logic                              reset_i,
	input  wire logic                              ce_i,
	// crystal timebase pin
	input  wire logic                              xtal_i,
	// register port
	input  wire logic [rtc_irq_pkg::ADDR_W-1:0]    reg_addr_i,
	input  wire logic [rtc_irq_pkg::DATA_W-1:0]    reg_wdata_i,
	input  wire logic                              reg_we_i,
	input  wire logic                              reg_re_i,
	output logic      [rtc_irq_pkg::DATA_W-1:0]    reg_rdata_o,
	// serial side reading the time registers
	input  wire logic                              time_read_busy_i,
	// open-drain interrupt pins
	output logic                                   irq_pin_a_o,
	output logic                                   irq_pin_a_oe_o,
	output logic                                   irq_pin_b_o,
	output logic                                   irq_pin_b_oe_o
);
	import rtc_irq_pkg::*;

	if (FREQ_TAPS_P < 1 || FREQ_TAPS_P > TAP_TOP + 1) begin : g_chk
		$error("frequency tap count outside the divider");
	end

	typedef struct packed {
		logic [2:0]             sync;
		logic                   xlvl;
		logic                   xtick;
		logic                   restart;
		logic [DATA_W-1:0]      rdata;
		logic                   pof;
		logic [DATA_W-1:0]      st2;
		logic [FREQ_TAPS_P-1:0] fsel_a;
		logic [FREQ_TAPS_P-1:0] fsel_b;
		logic [DATA_W-1:0]      trim;
		logic [3:0]             mmode;
		logic [SEC_W-1:0]       sec;
		logic                   pend;
		logic [HOLD_W-1:0]      hold;
		logic [EVT_W-1:0]       evt;
		logic                   edge_a;
		logic                   edge_b;
		logic                   run1_a;
		logic                   run1_b;
		logic                   oe_a;
		logic                   oe_b;
	} ctl_state_t;

	ctl_state_t s_q;
	ctl_state_t s_d;
	tick_if     tb ();

	// reset image: power-on flag set, pin a in 1 Hz frequency output
	localparam ctl_state_t RESET_STATE = '{
		sync: 3'h0, xlvl: 1'b0, xtick: 1'b0, restart: 1'b0, rdata: '0,
		pof: 1'b1, st2: ST2_RESET, fsel_a: FREQ_TAPS_P'(FSEL_A_RESET),
		fsel_b: FREQ_TAPS_P'(FSEL_B_RESET), trim: TRIM_RESET, mmode: 4'h0,
		sec: '0, pend: 1'b0, hold: '0, evt: '0, edge_a: 1'b0, edge_b: 1'b0,
		run1_a: 1'b0, run1_b: 1'b0, oe_a: 1'b0, oe_b: 1'b0
	};

	rate_trim_divider #(
		.DIV_W (CNT_W)
	) u_div (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.ce_i    (ce_i),
		.link    (tb.div)
	);

	// link to the divider comes straight from state flops
	assign tb.xtal_tick = s_q.xtick;
	assign tb.restart   = s_q.restart;
	assign tb.trim      = s_q.trim;

	// register reads see live state; unmapped offsets read zero
	function automatic logic [DATA_W-1:0] read_mux(input ctl_state_t s,
			input logic [ADDR_W-1:0] a);
		logic [DATA_W-1:0] v;
		v = '0;
		case (a)
			REG_STATUS1: v[ST1_POF_BIT] = s.pof;
			REG_STATUS2: v = s.st2;
			REG_FREQ_A:  v = DATA_W'(s.fsel_a);
			REG_FREQ_B:  v = DATA_W'(s.fsel_b);
			REG_TRIM:    v = s.trim;
			REG_MMODE:   v = DATA_W'(s.mmode);
			REG_SECONDS: v = DATA_W'(s.sec);
			default:     v = '0;
		endcase
		return v;
	endfunction : read_mux

	// pin-low request for one pin in its minute modes
	function automatic logic minute_low(input minute_mode_t m, input logic edge_l,
			input logic run1, input logic half, input logic evt_on, input logic allow2);
		logic low;
		low = 1'b0;
		case (m)
			MIN_EDGE:      low = edge_l;
			MIN_PERIODIC1: low = run1 & half;
			MIN_PERIODIC2: low = allow2 & evt_on;
			default:       low = edge_l;
		endcase
		return low;
	endfunction : minute_low

	always_comb begin
		logic                   carry;
		logic                   evt_on;
		logic                   low_half;
		logic [FREQ_TAPS_P-1:0] taps;
		logic                   freq_a;
		logic                   freq_b;
		logic                   me_a;
		logic                   me_b;
		logic                   low_a;
		logic                   low_b;
		minute_mode_t           mode_a;
		minute_mode_t           mode_b;
		carry    = 1'b0;
		evt_on   = 1'b0;
		low_half = 1'b0;
		taps     = '0;
		freq_a   = 1'b0;
		freq_b   = 1'b0;
		me_a     = 1'b0;
		me_b     = 1'b0;
		low_a    = 1'b0;
		low_b    = 1'b0;
		mode_a   = minute_mode_t'(s_q.mmode[1:0]);
		mode_b   = minute_mode_t'(s_q.mmode[3:2]);
		s_d      = s_q;

		// crystal pin: three flops, level taken once the last two agree
		s_d.sync = {s_q.sync[1:0], xtal_i};
		if (s_q.sync[1] == s_q.sync[2]) begin
			s_d.xlvl = s_q.sync[2];
		end
		s_d.xtick   = s_d.xlvl & ~s_q.xlvl;
		s_d.restart = 1'b0;

		// seconds count; the wrap leaves a carry pending
		if (tb.sec_tick) begin
			if (int'(s_q.sec) >= SEC_PER_MIN - 1) begin
				s_d.sec  = '0;
				s_d.pend = 1'b1;
			end else begin
				s_d.sec = SEC_W'(s_q.sec + 1'b1);
			end
		end

		// carry waits for a time read to finish, but never past the hold limit
		if (s_q.pend) begin
			if (!time_read_busy_i || int'(s_q.hold) >= HOLD_TICKS - 1) begin
				carry    = 1'b1;
				s_d.pend = 1'b0;
				s_d.hold = '0;
			end else if (s_q.xtick) begin
				s_d.hold = HOLD_W'(s_q.hold + 1'b1);
			end
		end

		// minute event window, counted in crystal periods
		evt_on = (s_q.evt != '0);
		if (carry) begin
			s_d.evt = EVT_W'(EVENT_TICKS);
		end else if (evt_on && s_q.xtick) begin
			s_d.evt = EVT_W'(s_q.evt - 1'b1);
		end
		low_half = (int'(s_q.sec) < HALF_MIN_S);

		// edge latch: cleared by disable, re-armed inside the event window
		me_a       = s_q.st2[ST2_ME_A] & ~s_q.st2[ST2_FE_A] & ~s_q.st2[ST2_KHZ];
		me_b       = s_q.st2[ST2_ME_B] & ~s_q.st2[ST2_FE_B];
		s_d.edge_a = me_a & (mode_a == MIN_EDGE) & (s_q.edge_a | carry | evt_on);
		s_d.edge_b = me_b & (mode_b == MIN_EDGE) & (s_q.edge_b | carry | evt_on);

		// periodic 1 run flag survives a disable only through the low half
		s_d.run1_a = (me_a && mode_a == MIN_PERIODIC1) ? (s_q.run1_a | carry)
		                                                : (s_q.run1_a & low_half);
		s_d.run1_b = (me_b && mode_b == MIN_PERIODIC1) ? (s_q.run1_b | carry)
		                                                : (s_q.run1_b & low_half);

		// frequency taps: tap k toggles at 2^k Hz; unselected taps read high
		for (int k = 0; k < FREQ_TAPS_P; k++) begin
			taps[k] = tb.div_cnt[TAP_TOP-k];
		end
		freq_a = &(taps | ~s_q.fsel_a);
		freq_b = &(taps | ~s_q.fsel_b);

		// pin a priority: 32 kHz, then frequency, then minute modes
		if (s_q.st2[ST2_KHZ]) begin
			low_a = ~s_q.xlvl;
		end else if (s_q.st2[ST2_FE_A]) begin
			low_a = ~freq_a;
		end else if (me_a) begin
			low_a = minute_low(mode_a, s_q.edge_a, s_q.run1_a, low_half, evt_on, 1'b1);
		end
		// pin b has no 32 kHz and no periodic mode 2
		if (s_q.st2[ST2_FE_B]) begin
			low_b = ~freq_b;
		end else if (me_b) begin
			low_b = minute_low(mode_b, s_q.edge_b, s_q.run1_b, low_half, evt_on, 1'b0);
		end
		s_d.oe_a = low_a;
		s_d.oe_b = low_b;

		// register port; reads answer in the next cycle only
		s_d.rdata = reg_re_i ? read_mux(s_q, reg_addr_i) : '0;
		if (reg_we_i) begin
			case (reg_addr_i)
				REG_STATUS1: begin
					if (reg_wdata_i[ST1_INIT_BIT]) begin
						// initialisation drops the power-on output mode
						s_d.pof    = 1'b0;
						s_d.st2    = '0;
						s_d.fsel_a = '0;
						s_d.fsel_b = '0;
						s_d.trim   = '0;
						s_d.mmode  = '0;
						s_d.sec    = '0;
						s_d.pend   = 1'b0;
						s_d.hold   = '0;
						s_d.restart = 1'b1;
					end else if (reg_wdata_i[ST1_POF_BIT]) begin
						s_d.pof = 1'b0;
					end
				end
				REG_STATUS2: s_d.st2    = reg_wdata_i;
				REG_FREQ_A:  s_d.fsel_a = reg_wdata_i[FREQ_TAPS_P-1:0];
				REG_FREQ_B:  s_d.fsel_b = reg_wdata_i[FREQ_TAPS_P-1:0];
				REG_TRIM:    s_d.trim   = reg_wdata_i;
				REG_MMODE:   s_d.mmode  = reg_wdata_i[3:0];
				REG_SECONDS: begin
					// a time write restarts the second and moves the next carry
					s_d.sec     = (int'(reg_wdata_i) < SEC_PER_MIN)
					              ? reg_wdata_i[SEC_W-1:0] : '0;
					s_d.pend    = 1'b0;
					s_d.hold    = '0;
					s_d.restart = 1'b1;
				end
				default: ;
			endcase
		end
	end

	// all control state in one register; ce low freezes everything
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			s_q <= RESET_STATE;
		end else if (ce_i) begin
			s_q <= s_d;
		end
	end

	// open drain: data held low, enable asserts the pull-down
	assign reg_rdata_o    = s_q.rdata;
	assign irq_pin_a_o    = s_q.rdata[0] & 1'b0;
	assign irq_pin_a_oe_o = s_q.oe_a;
	assign irq_pin_b_o    = s_q.rdata[0] & 1'b0;
	assign irq_pin_b_oe_o = s_q.oe_b;
endmodule : rtc_irq_output_and_trim

// ==== rtl/rtc_irq_pkg.sv ====
package rtc_irq_pkg;
	// timebase
	localparam int XTAL_HZ       = 32768;
	localparam int TAP_TOP       = 14;              // divider bit that toggles at 1 Hz
	localparam int EVENT_TIME_US = 7810;            // minute-edge event length
	localparam int EVENT_TICKS   = (XTAL_HZ * EVENT_TIME_US + 999_999) / 1_000_000;
	localparam int HOLD_TIME_MS  = 500;             // longest carry postponement
	localparam int HOLD_TICKS    = XTAL_HZ * HOLD_TIME_MS / 1000;
	localparam int SHORT_IVL_S   = 20;
	localparam int LONG_IVL_S    = 60;
	localparam int SEC_PER_MIN   = 60;
	localparam int HALF_MIN_S    = 30;
	localparam int TRIM_UNIT     = 2;               // crystal counts per correction step
	localparam int CNT_W         = 16;
	localparam int SEC_W         = 6;
	localparam int EVT_W         = 9;
	localparam int HOLD_W        = 15;
	localparam int FREQ_TAPS     = 5;
	localparam int ADDR_W        = 3;
	localparam int DATA_W        = 8;

	// register offsets
	localparam logic [ADDR_W-1:0] REG_STATUS1 = 3'h0;
	localparam logic [ADDR_W-1:0] REG_STATUS2 = 3'h1;
	localparam logic [ADDR_W-1:0] REG_FREQ_A  = 3'h2;
	localparam logic [ADDR_W-1:0] REG_FREQ_B  = 3'h3;
	localparam logic [ADDR_W-1:0] REG_TRIM    = 3'h4;
	localparam logic [ADDR_W-1:0] REG_MMODE   = 3'h5;
	localparam logic [ADDR_W-1:0] REG_SECONDS = 3'h6;

	// field positions
	localparam int ST1_POF_BIT  = 0;
	localparam int ST1_INIT_BIT = 7;
	localparam int ST2_FE_A     = 7;
	localparam int ST2_ME_A     = 6;
	localparam int ST2_AE_A     = 5;
	localparam int ST2_KHZ      = 4;
	localparam int ST2_FE_B     = 3;
	localparam int ST2_ME_B     = 2;
	localparam int ST2_AE_B     = 1;
	localparam int TRIM_IVL_BIT = 0;

	// reset values
	localparam logic [DATA_W-1:0]    ST2_RESET    = 8'h80;
	localparam logic [FREQ_TAPS-1:0] FSEL_A_RESET = 5'h01;   // 1 Hz tap only
	localparam logic [FREQ_TAPS-1:0] FSEL_B_RESET = 5'h00;
	localparam logic [DATA_W-1:0]    TRIM_RESET   = 8'h00;

	typedef enum logic [1:0] {
		MIN_EDGE,
		MIN_PERIODIC1,
		MIN_PERIODIC2
	} minute_mode_t;
endpackage : rtc_irq_pkg

// ==== rtl/tick_if.sv ====
`timescale 1ns/1ps
interface tick_if;
	import rtc_irq_pkg::*;
	logic                     xtal_tick;
	logic                     restart;
	logic [DATA_W-1:0]        trim;
	logic                     sec_tick;
	logic [CNT_W-1:0]         div_cnt;

	modport div (input xtal_tick, input restart, input trim, output sec_tick, output div_cnt);
	modport ctl (output xtal_tick, output restart, output trim, input sec_tick, input div_cnt);
endinterface : tick_if

// ==== tb/rtc_host_model.sv ====
`timescale 1ns/1ps
module rtc_host_model (
	// bench clock, only to phase the crystal
	input  wire logic clk_i,
	// pins of the block
	input  wire logic pin_a_i,
	input  wire logic pin_a_oe_i,
	input  wire logic pin_b_i,
	input  wire logic pin_b_oe_i,
	// crystal and wire levels
	output logic      xtal_o,
	output logic      level_a_o,
	output logic      level_b_o
);
	int ph;
	initial begin
		ph = 0;
		xtal_o = 1'b0;
	end
	// crystal stand-in: three clocks a level, one more than the two the sync needs
	always @(negedge clk_i) begin
		ph <= (ph == 2) ? 0 : ph + 1;
		if (ph == 2) xtal_o <= ~xtal_o;
	end
	// wired lines with pull-up: a released pin reads high
	assign level_a_o = pin_a_oe_i ? pin_a_i : 1'b1;
	assign level_b_o = pin_b_oe_i ? pin_b_i : 1'b1;
endmodule : rtc_host_model

// ==== tb/rtc_irq_output_and_trim_test.sv ====
`timescale 1ns/1ps
module rtc_irq_output_and_trim_test;
	import rtc_irq_pkg::*;
	logic              clk_i = 1'b0;
	logic              reset_i = 1'b1;
	logic              ce_i = 1'b1;
	logic              time_read_busy_i = 1'b0;
	logic              reg_we_i = 1'b0;
	logic              reg_re_i = 1'b0;
	logic [ADDR_W-1:0] reg_addr_i = '0;
	logic [DATA_W-1:0] reg_wdata_i = '0;
	logic [DATA_W-1:0] reg_rdata_o;
	logic              xtal_i, pin_a, pin_a_oe, pin_b, pin_b_oe, level_a, level_b;
	logic [4:0]        tb_sel;
	int                n_fail = 0;
	int                check_count = 0;
	int                seed = 49;
	int                regs[8];
	int                ha, hb, steps, keep;
	bit                fast;

	always #12.5 clk_i = ~clk_i;

	rtc_irq_output_and_trim i_rtc_irq_output_and_trim (.clk_i(clk_i), .reset_i(reset_i),
		.ce_i(ce_i), .xtal_i(xtal_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
		.time_read_busy_i(time_read_busy_i), .irq_pin_a_o(pin_a), .irq_pin_a_oe_o(pin_a_oe),
		.irq_pin_b_o(pin_b), .irq_pin_b_oe_o(pin_b_oe));
	rtc_host_model i_rtc_host_model (.clk_i(clk_i), .pin_a_i(pin_a), .pin_a_oe_i(pin_a_oe),
		.pin_b_i(pin_b), .pin_b_oe_i(pin_b_oe), .xtal_o(xtal_i), .level_a_o(level_a),
		.level_b_o(level_b));

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// one write cycle, then the register model follows
	task automatic wr(input int a, input int d);
		@(posedge clk_i);
		reg_we_i <= 1'b1;
		reg_addr_i <= ADDR_W'(a);
		reg_wdata_i <= DATA_W'(d);
		@(posedge clk_i);
		reg_we_i <= 1'b0;
		case (a)
			0: if (d[7]) regs = '{default: 0}; else if (d[0]) regs[0] = 0;
			1: regs[1] = d;
			2, 3: regs[a] = d & 'h1F;
			4: regs[4] = d;
			5: regs[5] = d & 'h0F;
			6: regs[6] = (d > 59) ? 0 : d;
			default: ;
		endcase
	endtask : wr

	// read data stand only in the cycle after the read edge
	task automatic rd(input int a);
		@(posedge clk_i);
		reg_re_i <= 1'b1;
		reg_addr_i <= ADDR_W'(a);
		@(posedge clk_i);
		reg_re_i <= 1'b0;
		#1 check($sformatf("reg %0d", a), {8'h00, reg_rdata_o}, 16'(regs[a]));
	endtask : rd

	// one sample per crystal period, so each divider value is seen once
	task automatic count_high(input int n);
		ha = 0;
		hb = 0;
		repeat (n) begin
			repeat (6) @(posedge clk_i);
			#1;
			ha += int'(level_a);
			hb += int'(level_b);
		end
	endtask : count_high

	function automatic int trim_byte(input bit f, input int s, input bit ivl);
		logic [6:0] v;
		logic [7:0] b;
		v = f ? 7'(128 - s) : 7'(s);
		for (int i = 0; i < 7; i++) b[7-i] = v[i];
		b[0] = ivl;
		return int'(b);
	endfunction : trim_byte

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop

	// watchdog at 2 ms, past the ~1.31 ms the sequence needs, under 100k clocks
	initial begin
		#2_000_000;
		n_fail++;
		report_and_stop;
	end

	// main sequence
	initial begin
		regs = '{1, 'h80, 1, 0, 0, 0, 0, 0};
		repeat (6) @(posedge clk_i);
		reset_i <= 1'b0;
		repeat (20) @(posedge clk_i);
		#1 check("pin a at power-on", level_a, 1'b0);
		for (int a = 0; a < 8; a++) rd(a);
		wr(0, 'h01);
		rd(0);
		wr(2, 0);
		wr(1, 'h80);
		count_high(256);
		check("empty select a", 16'(ha), 16'd256);
		wr(2, 'h18);
		count_high(4096);
		check("and of taps a", 16'(ha), 16'(4096 >> 2));
		check("pin b idle", 16'(hb), 16'd4096);
		tb_sel = {1'b1, 1'($random(seed)), 3'b000};
		wr(3, 0);
		wr(1, 'h08);
		wr(3, int'(tb_sel));
		count_high(4096);
		check("and of taps b", 16'(hb), 16'(4096 >> $countones(tb_sel)));
		check("pin a stopped", 16'(ha), 16'd4096);
		wr(6, 0);
		wr(5, 0);
		wr(1, 'h40);
		count_high(256);
		check("edge mode before carry", 16'(ha), 16'd256);
		repeat (4) begin
			fast = 1'($random(seed));
			steps = ($random(seed) & 'h3F) % (fast ? 65 : 63);
			wr(4, trim_byte(fast, steps, 1'($random(seed))));
			rd(4);
		end
		// strobes while the clock enable is low must leave the register alone
		keep = regs[3];
		@(posedge clk_i);
		ce_i <= 1'b0;
		wr(3, keep ^ 'h07);
		regs[3] = keep;
		@(posedge clk_i);
		ce_i <= 1'b1;
		rd(3);
		wr(4, 0);
		rd(4);
		wr(6, 75);
		rd(6);
		wr(6, 59);
		rd(6);
		wr(0, 'h80);
		for (int a = 0; a < 8; a++) rd(a);
		report_and_stop;
	end
endmodule : rtc_irq_output_and_trim_test

// ==== tb/rtc_irq_props.sv ====
`timescale 1ns/1ps
module rtc_irq_props #(
	parameter int FREQ_TAPS_P = rtc_irq_pkg::FREQ_TAPS
) (
	// clock and control
	input wire logic                           clk_i,
	input wire logic                           reset_i,
	input wire logic                           ce_i,
	input wire logic                           xtal_i,
	input wire logic                           time_read_busy_i,
	// register port
	input wire logic [rtc_irq_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [rtc_irq_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic                           reg_we_i,
	input wire logic                           reg_re_i,
	input wire logic [rtc_irq_pkg::DATA_W-1:0] reg_rdata_o,
	// pins
	input wire logic                           irq_pin_a_o,
	input wire logic                           irq_pin_a_oe_o,
	input wire logic                           irq_pin_b_o,
	input wire logic                           irq_pin_b_oe_o
);
	import rtc_irq_pkg::*;
	typedef struct packed {
		logic [DATA_W-1:0]      st2;
		logic [FREQ_TAPS_P-1:0] fa;
		logic                   pof;
	} shadow_t;
	shadow_t s_q;
	shadow_t s_d;
	logic    wr_ok;
	assign wr_ok = ce_i && reg_we_i;
	// mirror of host writes, so pin checks know which enables are set
	always_comb begin
		s_d = s_q;
		if (wr_ok && reg_addr_i == REG_STATUS2) s_d.st2 = reg_wdata_i;
		if (wr_ok && reg_addr_i == REG_FREQ_A) s_d.fa = reg_wdata_i[FREQ_TAPS_P-1:0];
		if (wr_ok && reg_addr_i == REG_STATUS1 && reg_wdata_i[ST1_POF_BIT]) s_d.pof = 1'b0;
		if (wr_ok && reg_addr_i == REG_STATUS1 && reg_wdata_i[ST1_INIT_BIT]) s_d = '0;
	end
	// power-on values as the reset loads them
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			s_q <= '{st2: ST2_RESET, fa: FREQ_TAPS_P'(FSEL_A_RESET), pof: 1'b1};
		end else begin
			s_q <= s_d;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	a_flag_read: assert property (
		ce_i && reg_re_i && reg_addr_i == REG_STATUS1 |=> reg_rdata_o[0] == $past(s_q.pof))
		else $error("power-on flag reads wrong");
	a_status2_read: assert property (
		ce_i && reg_re_i && reg_addr_i == REG_STATUS2
		|=> (reg_rdata_o & 8'hFE) == ($past(s_q.st2) & 8'hFE))
		else $error("status 2 reads wrong");
	a_select_read: assert property (
		ce_i && reg_re_i && reg_addr_i == REG_FREQ_A
		|=> reg_rdata_o[FREQ_TAPS_P-1:0] == $past(s_q.fa))
		else $error("pin a select reads wrong");
	a_open_drain: assert property (
		irq_pin_a_o == 1'b0 && irq_pin_b_o == 1'b0)
		else $error("pin data not held low");
	a_a_released: assert property (
		!(s_q.st2[ST2_FE_A] || s_q.st2[ST2_ME_A] || s_q.st2[ST2_KHZ]) [*3] |-> !irq_pin_a_oe_o)
		else $error("pin a driven with no mode");
	a_b_released: assert property (
		!(s_q.st2[ST2_FE_B] || s_q.st2[ST2_ME_B]) [*3] |-> !irq_pin_b_oe_o)
		else $error("pin b driven with no mode");
	a_no_taps: assert property (
		(s_q.st2[ST2_FE_A] && !s_q.st2[ST2_KHZ] && s_q.fa == '0) [*3] |-> !irq_pin_a_oe_o)
		else $error("pin a driven with empty select");
	a_poweron_pin: assert property (
		$fell(reset_i) |-> ##[0:8] irq_pin_a_oe_o)
		else $error("pin a not low at power-on");
endmodule : rtc_irq_props

bind rtc_irq_output_and_trim rtc_irq_props #(.FREQ_TAPS_P(FREQ_TAPS_P)) i_rtc_irq_props (
	.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .xtal_i(xtal_i),
	.time_read_busy_i(time_read_busy_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
	.reg_rdata_o(reg_rdata_o), .irq_pin_a_o(irq_pin_a_o), .irq_pin_a_oe_o(irq_pin_a_oe_o),
	.irq_pin_b_o(irq_pin_b_o), .irq_pin_b_oe_o(irq_pin_b_oe_o));
